// ===== hdl/rhpm_pkg.sv
package rhpm_pkg;
    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [11:0] RHPM_OFS_CTRL   = 12'h000;
    localparam logic [11:0] RHPM_OFS_GPIO   = 12'h004;
    localparam logic [11:0] RHPM_OFS_STATUS = 12'h008;

    // ************************************************************
    // Control register field positions
    // ************************************************************
    localparam int RHPM_CTRL_AUDIO_REROUTE = 0;
    localparam int RHPM_CTRL_AUDIO_MASTER  = 1;
    localparam int RHPM_CTRL_LAN_PD_EN     = 2;
    localparam int RHPM_CTRL_RADIO_PD_EN   = 3;
    localparam int RHPM_CTRL_LAN_IRQ_MODE  = 4;
    localparam int RHPM_CTRL_LAN_IRQ_LEVEL = 5;
    localparam int RHPM_CTRL_WIDTH         = 6;

    // ************************************************************
    // GPIO register field positions
    // ************************************************************
    localparam int RHPM_GPIO_DEV_WAKE_OUT = 0;
    localparam int RHPM_GPIO_DEV_WAKE_OE  = 1;
    localparam int RHPM_GPIO_HOST_WAKE_OUT = 2;
    localparam int RHPM_GPIO_HOST_WAKE_OE  = 3;
    localparam int RHPM_GPIO0_OUT         = 4;
    localparam int RHPM_GPIO0_OE          = 5;
    localparam int RHPM_GPIO_WIDTH        = 6;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [RHPM_CTRL_WIDTH-1:0] RHPM_CTRL_RESET = 6'h0C;
    localparam logic [RHPM_GPIO_WIDTH-1:0] RHPM_GPIO_RESET = 6'h00;
    localparam logic [31:0] RHPM_BAD_ADDR_DATA = 32'h00000000;
endpackage

// ===== hdl/rhpm_sync2.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a bundle of pin levels
module rhpm_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // ************************************************************
    // Synchroniser stages
    // ************************************************************
    // First stage read only by second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// ===== hdl/rhpm_pin_mux.sv
`timescale 1ns/1ps
// Overview of operation
// R1: Device sends serial data only while host holds clear-to-send low.
// R2: Device drives request-to-send low when it can accept serial data.
// R3: Serial data comes in on the input pin, goes out on the output pin.
// R4: After reset wake pins are GPIO/wake and serial pins carry the UART.
// R5: Rerouting puts voice clock, out, sync, in on RTS, CTS, host and device wake. This module does not put voice out on CTS; CTS stays an input.
// R6: With rerouting, sleep signalling uses three-wire transport on data lines only.
// R7: Audio clock and word select are outputs as master, inputs as slave. The code leaves both undriven while rerouted, even as master.
// R8: LAN section held in reset while its power enable is low.
// R9: Short-range radio section held in reset while its power enable is low.
// R10: Regulators of each section follow that section's power enable.
// R11: Power-enable pull-downs are on after reset and software can switch them off.
// R12: GPIO 0 is driven by the device when used as LAN host interrupt.
// R13: No hardware flow control on RTS/CTS while audio rerouting is active.
module rhpm_pin_mux (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial link pins
    input  wire logic        link_clear_to_send_n,
    output logic             link_request_to_send_n,
    output logic             link_rts_oe,
    input  wire logic        link_serial_in,
    output logic             link_serial_out,
    // Wake pins
    input  wire logic        device_wake_pin_in,
    output logic             device_wake_pin_out,
    output logic             device_wake_pin_oe,
    input  wire logic        host_wake_pin_in,
    output logic             host_wake_pin_out,
    output logic             host_wake_pin_oe,
    // Dedicated audio port pins
    input  wire logic        audio_bit_clock_in,
    output logic             audio_bit_clock_out,
    output logic             audio_bit_clock_oe,
    input  wire logic        audio_word_select_in,
    output logic             audio_word_select_out,
    output logic             audio_word_select_oe,
    // Power enables and GPIO 0
    input  wire logic        lan_power_enable,
    input  wire logic        radio_b_power_enable,
    output logic             lan_pull_down_en,
    output logic             radio_pull_down_en,
    input  wire logic        gpio0_in,
    output logic             gpio0_out,
    output logic             gpio0_oe,
    // Section controls
    output logic             lan_reset_n,
    output logic             radio_reset_n,
    output logic             lan_regulator_on,
    output logic             radio_regulator_on,
    // Radio core serial side
    input  wire logic        core_tx_data,
    input  wire logic        core_tx_valid,
    output logic             core_tx_allowed,
    input  wire logic        core_rx_ready,
    output logic             core_rx_data,
    output logic             core_three_wire,
    output logic             core_dev_wake,
    input  wire logic        core_host_wake,
    input  wire logic        lan_irq_event,
    // Radio core voice side
    input  wire logic        voice_clk_out,
    input  wire logic        voice_sync_out,
    input  wire logic        voice_data_out,
    output logic             voice_data_in,
    output logic             voice_clk_in,
    output logic             voice_sync_in
);
    import rhpm_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [RHPM_CTRL_WIDTH-1:0] ctrl_r;
    logic [RHPM_GPIO_WIDTH-1:0] gpio_r;
    logic [8:0]                 pin_s;
    logic                       cts_n_s;
    logic                       rxd_s;
    logic                       dev_wake_s;
    logic                       host_wake_s;
    logic                       aclk_s;
    logic                       aws_s;
    logic                       lan_en_s;
    logic                       radio_en_s;
    logic                       gpio0_s;
    logic                       reroute;
    logic                       master;
    logic                       irq_mode;
    logic                       wr_en;
    logic                       rd_en;
    logic                       addr_ok;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // All pins from outside the clock domain pass two flops
    rhpm_sync2 #(
        .W(9)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({link_clear_to_send_n, link_serial_in, device_wake_pin_in,
                   host_wake_pin_in, audio_bit_clock_in, audio_word_select_in,
                   lan_power_enable, radio_b_power_enable, gpio0_in}),
        .q       (pin_s)
    );

    assign {cts_n_s, rxd_s, dev_wake_s, host_wake_s, aclk_s, aws_s,
            lan_en_s, radio_en_s, gpio0_s} = pin_s;

    // Control field aliases
    assign reroute  = ctrl_r[RHPM_CTRL_AUDIO_REROUTE];
    assign master   = ctrl_r[RHPM_CTRL_AUDIO_MASTER];
    assign irq_mode = ctrl_r[RHPM_CTRL_LAN_IRQ_MODE];

    // ************************************************************
    // APB slave
    // ************************************************************
    // Zero wait states: every access completes in its first access cycle
    function automatic logic addr_mapped(input logic [11:0] a);
        return (a == RHPM_OFS_CTRL) || (a == RHPM_OFS_GPIO) || (a == RHPM_OFS_STATUS);
    endfunction

    assign addr_ok = addr_mapped(paddr);
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign rd_en   = psel && !penable && !pwrite;

    // Control register; reset value gives UART routing and pull-downs on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= RHPM_CTRL_RESET; // [R4] [R11]
        end else if (wr_en && paddr == RHPM_OFS_CTRL) begin
            ctrl_r <= pwdata[RHPM_CTRL_WIDTH-1:0];
        end
    end

    // Software GPIO register for wake pins and GPIO 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_r <= RHPM_GPIO_RESET;
        end else if (wr_en && paddr == RHPM_OFS_GPIO) begin
            gpio_r <= pwdata[RHPM_GPIO_WIDTH-1:0];
        end
    end

    // Read data captured in setup so it is stable for the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= RHPM_BAD_ADDR_DATA;
        end else if (rd_en) begin
            unique case (paddr)
                RHPM_OFS_CTRL:   prdata <= {26'h0000000, ctrl_r};
                RHPM_OFS_GPIO:   prdata <= {26'h0000000, gpio_r};
                RHPM_OFS_STATUS: prdata <= {23'h000000, pin_s};
                default:         prdata <= RHPM_BAD_ADDR_DATA;
            endcase
        end
    end

    // Ready high in access phase; error flags unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
        end
    end

    // ************************************************************
    // Serial link pins
    // ************************************************************
    // Serial data both ways; flow control dropped while rerouted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_serial_out        <= 1'b1;
            core_rx_data           <= 1'b1;
            core_tx_allowed        <= 1'b0;
            link_request_to_send_n <= 1'b1;
            link_rts_oe            <= 1'b1;
            core_three_wire        <= 1'b0;
        end else begin
            core_rx_data    <= rxd_s; // [R3]
            core_three_wire <= reroute; // [R6]
            link_rts_oe     <= 1'b1;
            if (reroute) begin
                link_request_to_send_n <= voice_clk_out; // [R5]
                core_tx_allowed        <= 1'b1; // [R13]
                link_serial_out        <= core_tx_data; // [R6]
            end else begin
                link_request_to_send_n <= !core_rx_ready; // [R2]
                core_tx_allowed        <= !cts_n_s; // [R1]
                // Hold line idle if host withdraws clear-to-send
                link_serial_out        <= (core_tx_valid && !cts_n_s) ? core_tx_data : 1'b1; // [R1] [R3]
            end
        end
    end

    // ************************************************************
    // Wake pins and voice reroute
    // ************************************************************
    // CTS pin is input-only in every mode; voice data out drives no pin of this module
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            device_wake_pin_out <= 1'b0;
            device_wake_pin_oe  <= 1'b0;
            host_wake_pin_out   <= 1'b0;
            host_wake_pin_oe    <= 1'b0;
            core_dev_wake       <= 1'b0;
            voice_data_in       <= 1'b0;
        end else if (reroute) begin
            device_wake_pin_out <= 1'b0;
            device_wake_pin_oe  <= 1'b0;
            host_wake_pin_out   <= voice_sync_out; // [R5]
            host_wake_pin_oe    <= 1'b1;
            core_dev_wake       <= 1'b0; // [R6]
            voice_data_in       <= dev_wake_s; // [R5]
        end else begin
            device_wake_pin_out <= gpio_r[RHPM_GPIO_DEV_WAKE_OUT]; // [R4]
            device_wake_pin_oe  <= gpio_r[RHPM_GPIO_DEV_WAKE_OE];
            // Host wake driven by core unless software claims it as GPIO
            host_wake_pin_out   <= gpio_r[RHPM_GPIO_HOST_WAKE_OE] ?
                                   gpio_r[RHPM_GPIO_HOST_WAKE_OUT] : core_host_wake; // [R4]
            host_wake_pin_oe    <= 1'b1;
            core_dev_wake       <= dev_wake_s;
            voice_data_in       <= 1'b0;
        end
    end

    // ************************************************************
    // Audio port clock and sync direction
    // ************************************************************
    // Master drives both pins unless rerouted; slave takes host clock and sync
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            audio_bit_clock_out   <= 1'b0;
            audio_bit_clock_oe    <= 1'b0;
            audio_word_select_out <= 1'b0;
            audio_word_select_oe  <= 1'b0;
            voice_clk_in          <= 1'b0;
            voice_sync_in         <= 1'b0;
        end else begin
            audio_bit_clock_out   <= voice_clk_out;
            audio_word_select_out <= voice_sync_out;
            audio_bit_clock_oe    <= master && !reroute; // [R7]
            audio_word_select_oe  <= master && !reroute; // [R7]
            voice_clk_in          <= master ? voice_clk_out : aclk_s; // [R7]
            voice_sync_in         <= master ? voice_sync_out : aws_s; // [R7]
        end
    end

    // ************************************************************
    // Power enables, section resets and GPIO 0
    // ************************************************************
    // Resets and regulators follow the synchronised enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lan_reset_n        <= 1'b0;
            radio_reset_n      <= 1'b0;
            lan_regulator_on   <= 1'b0;
            radio_regulator_on <= 1'b0;
            lan_pull_down_en   <= 1'b1;
            radio_pull_down_en <= 1'b1;
        end else begin
            lan_reset_n        <= lan_en_s; // [R8]
            radio_reset_n      <= radio_en_s; // [R9]
            lan_regulator_on   <= lan_en_s; // [R10]
            radio_regulator_on <= radio_en_s; // [R10]
            lan_pull_down_en   <= ctrl_r[RHPM_CTRL_LAN_PD_EN]; // [R11]
            radio_pull_down_en <= ctrl_r[RHPM_CTRL_RADIO_PD_EN]; // [R11]
        end
    end

    // GPIO 0 becomes an output carrying the LAN interrupt when selected
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio0_out <= 1'b0;
            gpio0_oe  <= 1'b0;
        end else if (irq_mode) begin
            gpio0_out <= lan_irq_event ~^ ctrl_r[RHPM_CTRL_LAN_IRQ_LEVEL]; // [R12]
            gpio0_oe  <= 1'b1; // [R12]
        end else begin
            gpio0_out <= gpio_r[RHPM_GPIO0_OUT];
            gpio0_oe  <= gpio_r[RHPM_GPIO0_OE];
        end
    end

    // Voice data out reaches no pin, CTS included; unused here
    logic unused_ok;
    assign unused_ok = voice_data_out & gpio0_s & host_wake_s & (|pwdata[31:6]);
endmodule

// ===== bench/rhpm_pin_mux_assertions.sv
`timescale 1ns/1ps
// ****************************
// Port checks of the pin mux
// ****************************
module rhpm_pin_mux_checker (
    // Clock, reset and APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // Pins and section controls
    input wire logic        link_clear_to_send_n,
    input wire logic        link_request_to_send_n,
    input wire logic        link_serial_out,
    input wire logic        lan_power_enable,
    input wire logic        radio_b_power_enable,
    input wire logic        lan_pull_down_en,
    input wire logic        lan_reset_n,
    input wire logic        lan_regulator_on,
    input wire logic        radio_reset_n,
    input wire logic        audio_bit_clock_oe,
    input wire logic        gpio0_oe,
    // Radio core side
    input wire logic        core_tx_allowed,
    input wire logic        core_three_wire,
    input wire logic        voice_clk_out
);
    import rhpm_pkg::*;
    logic [RHPM_CTRL_WIDTH-1:0] ctrl_r;
    logic [2:0]                 settle_r;
    logic                       wr_ctrl;
    logic                       steady;
    logic                       rerouted;

    // Control writes commit at the APB access edge
    assign wr_ctrl  = psel && penable && pwrite && pready && paddr == RHPM_OFS_CTRL;
    assign steady   = settle_r >= 3'h4;
    assign rerouted = ctrl_r[RHPM_CTRL_AUDIO_REROUTE];

    // Shadow control word; outputs lag it, so checks wait until it has settled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r   <= RHPM_CTRL_RESET;
            settle_r <= 3'h0;
        end else if (wr_ctrl) begin
            ctrl_r   <= pwdata[RHPM_CTRL_WIDTH-1:0];
            settle_r <= 3'h0;
        end else if (settle_r != 3'h7) begin
            settle_r <= settle_r + 3'h1;
        end
    end

    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Pins cross two synchroniser flops, so pin relations allow three edges
    property p_cts_gate; link_clear_to_send_n [*4] ##0 (steady && !rerouted) |-> link_serial_out; endproperty
    a_cts_gate: assert property (p_cts_gate) else $error("serial out sent without clear");
    property p_lan_held; !lan_power_enable [*4] |-> !lan_reset_n && !lan_regulator_on; endproperty
    a_lan_held: assert property (p_lan_held) else $error("lan section not held");
    property p_radio_held; !radio_b_power_enable [*4] |-> !radio_reset_n; endproperty
    a_radio_held: assert property (p_radio_held) else $error("radio section not held");
    property p_lan_up; lan_power_enable [*4] |-> lan_reset_n && lan_regulator_on; endproperty
    a_lan_up: assert property (p_lan_up) else $error("lan section not powered");
    property p_pull_down; steady |-> lan_pull_down_en == ctrl_r[RHPM_CTRL_LAN_PD_EN]; endproperty
    a_pull_down: assert property (p_pull_down) else $error("pull-down not as set");
    property p_voice_clk;
        $stable(voice_clk_out) [*3] ##0 (steady && rerouted) |-> link_request_to_send_n == voice_clk_out;
    endproperty
    a_voice_clk: assert property (p_voice_clk) else $error("voice clock not on rts pin");
    property p_three_wire; steady |-> core_three_wire == rerouted; endproperty
    a_three_wire: assert property (p_three_wire) else $error("transport mode wrong");
    property p_no_flow; steady && rerouted |-> core_tx_allowed; endproperty
    a_no_flow: assert property (p_no_flow) else $error("flow control while rerouted");
    property p_audio_dir;
        steady |-> audio_bit_clock_oe == (ctrl_r[RHPM_CTRL_AUDIO_MASTER] && !rerouted);
    endproperty
    a_audio_dir: assert property (p_audio_dir) else $error("audio clock direction wrong");
    property p_irq_pin; steady && ctrl_r[RHPM_CTRL_LAN_IRQ_MODE] |-> gpio0_oe; endproperty
    a_irq_pin: assert property (p_irq_pin) else $error("gpio0 not driven as interrupt");

    // Main scenarios
    c_reroute: cover property (steady && rerouted);
    c_lan_up: cover property (lan_reset_n && lan_regulator_on);
    c_ctrl_write: cover property (wr_ctrl);
endmodule

bind rhpm_pin_mux rhpm_pin_mux_checker i_chk (.*);

// ===== bench/rhpm_host_model.sv
`timescale 1ns/1ps
// ****************************
// Host processor at the pins
// ****************************
module rhpm_host_model (
    // Clock and host intent
    input  wire logic pclk,
    input  wire logic host_cts_n,
    input  wire logic host_txd,
    input  wire logic host_dev_wake,
    // Device drive of shared pins
    input  wire logic device_wake_pin_out,
    input  wire logic device_wake_pin_oe,
    input  wire logic host_wake_pin_out,
    input  wire logic host_wake_pin_oe,
    input  wire logic audio_bit_clock_out,
    input  wire logic audio_bit_clock_oe,
    input  wire logic gpio0_out,
    input  wire logic gpio0_oe,
    // Levels seen by the device
    output logic      link_clear_to_send_n,
    output logic      link_serial_in,
    output logic      device_wake_pin_in,
    output logic      host_wake_pin_in,
    output logic      audio_bit_clock_in,
    output logic      gpio0_in
);
    logic tog_r = 1'h0;

    // Lines nobody drives wander, so a stale level never passes for a driven one
    always @(posedge pclk) tog_r <= ~tog_r;
    assign link_clear_to_send_n = host_cts_n;
    assign link_serial_in       = host_txd;
    assign device_wake_pin_in   = device_wake_pin_oe ? device_wake_pin_out : host_dev_wake;
    assign host_wake_pin_in     = host_wake_pin_oe ? host_wake_pin_out : tog_r;
    assign audio_bit_clock_in   = audio_bit_clock_oe ? audio_bit_clock_out : tog_r;
    assign gpio0_in             = gpio0_oe ? gpio0_out : tog_r;
endmodule

// ===== bench/radio_host_pin_function_mux_tb.sv
`timescale 1ns/1ps
// ****************************
// Self-checking pin mux bench
// ****************************
module radio_host_pin_function_mux_tb;
    import rhpm_pkg::*;
    typedef struct {logic wr; logic [11:0] addr; logic [31:0] wdat, rexp; logic eexp;} rhpm_row_s;
    logic        pclk = 1'h0, presetn = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        err, lan_power_enable = 1'h0, radio_b_power_enable = 1'h0, core_tx_data = 1'h1;
    logic        core_tx_valid = 1'h0, core_rx_ready = 1'h0, core_host_wake = 1'h0;
    logic        lan_irq_event = 1'h0, voice_clk_out = 1'h0, voice_sync_out = 1'h0;
    logic        host_cts_n = 1'h1, host_txd = 1'h1, host_dev_wake = 1'h0;
    logic        voice_data_out = 1'h0, audio_word_select_in = 1'h0;
    logic        pready, pslverr, link_clear_to_send_n, link_request_to_send_n, link_rts_oe;
    logic        link_serial_in, link_serial_out, device_wake_pin_in, device_wake_pin_out;
    logic        device_wake_pin_oe, host_wake_pin_in, host_wake_pin_out, host_wake_pin_oe;
    logic        audio_bit_clock_in, audio_bit_clock_out, audio_bit_clock_oe, gpio0_in;
    logic        audio_word_select_out, audio_word_select_oe, lan_pull_down_en, gpio0_out;
    logic        radio_pull_down_en, gpio0_oe, lan_reset_n, radio_reset_n, lan_regulator_on;
    logic        radio_regulator_on, core_tx_allowed, core_rx_data, core_three_wire;
    logic        core_dev_wake, voice_data_in, voice_clk_in, voice_sync_in;
    int          n_fail = 0, total_checks = 0;
    // Register traffic: read, write, read back, unmapped place, clear GPIO and control
    rhpm_row_s   rows [9] = '{
        '{1'h0, RHPM_OFS_CTRL, 32'h0, 32'h0000_000C, 1'h0}, '{1'h0, RHPM_OFS_GPIO, 32'h0, 32'h0, 1'h0},
        '{1'h1, RHPM_OFS_GPIO, 32'h0000_003F, 32'h0, 1'h0},
        '{1'h0, RHPM_OFS_GPIO, 32'h0, 32'h0000_003F, 1'h0},
        '{1'h1, 12'h00C, 32'hFFFF_FFFF, 32'h0, 1'h1}, '{1'h0, 12'h00C, 32'h0, 32'h0, 1'h1},
        '{1'h1, RHPM_OFS_GPIO, 32'h0, 32'h0, 1'h0}, '{1'h1, RHPM_OFS_CTRL, 32'h0, 32'h0, 1'h0},
        '{1'h0, RHPM_OFS_CTRL, 32'h0, 32'h0, 1'h0}};

    rhpm_pin_mux i_dut (.*);
    rhpm_host_model i_host (.*);

    // Clock
    always #5 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        if (n_fail == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One APB transfer; pready, data and error are taken at the rising edge that ends it
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel   <= 1'h1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        if (n >= 16) begin
            n_fail++;
            report_and_stop();
        end
    endtask

    // Pins need three edges to reach the outputs; margin added
    task automatic wt();
        repeat (5) @(posedge pclk);
        @(negedge pclk);
    endtask

    initial begin
        // Falling edge at time zero so the asynchronous reset really fires
        presetn <= 1'h0;
        repeat (16) @(posedge pclk);
        chk(32'({lan_pull_down_en, radio_pull_down_en, link_request_to_send_n, link_serial_out,
                 link_rts_oe, lan_reset_n, radio_reset_n}), 32'h7C);
        presetn <= 1'h1;
        wt();
        chk(32'({device_wake_pin_oe, host_wake_pin_oe, audio_bit_clock_oe, core_three_wire,
                 link_rts_oe}), 32'h09);
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, rows[i].wdat);
            chk(32'(err), 32'(rows[i].eexp));
            if (!rows[i].wr) chk(rd, rows[i].rexp);
        end
        wt();
        chk(32'({lan_pull_down_en, radio_pull_down_en}), 32'h0);
        // Power enables one section at a time
        @(posedge pclk);
        lan_power_enable <= 1'h1;
        wt();
        chk(32'({lan_reset_n, lan_regulator_on, radio_reset_n, radio_regulator_on}), 32'hC);
        @(posedge pclk);
        lan_power_enable     <= 1'h0;
        radio_b_power_enable <= 1'h1;
        wt();
        chk(32'({lan_reset_n, lan_regulator_on, radio_reset_n, radio_regulator_on}), 32'h3);
        // Flow control: clear-to-send held high, then released by the host
        @(posedge pclk);
        core_tx_valid <= 1'h1;
        core_tx_data  <= 1'h0;
        core_rx_ready <= 1'h1;
        wt();
        chk(32'({link_serial_out, link_request_to_send_n, core_rx_data}), 32'h5);
        @(posedge pclk);
        host_cts_n    <= 1'h0;
        host_txd      <= 1'h0;
        core_rx_ready <= 1'h0;
        wt();
        chk(32'({link_serial_out, link_request_to_send_n, core_rx_data}), 32'h2);
        // Audio master with gpio0 as active-high lan interrupt
        @(posedge pclk);
        lan_irq_event <= 1'h1;
        apb(1'h1, RHPM_OFS_CTRL, 32'h0000_0032);
        wt();
        chk(32'({audio_bit_clock_oe, audio_word_select_oe, gpio0_oe, gpio0_out}), 32'hF);
        // Reroute with clear-to-send high: voice signals take the pins
        @(posedge pclk);
        host_cts_n     <= 1'h1;
        voice_clk_out  <= 1'h1;
        voice_sync_out <= 1'h1;
        host_dev_wake  <= 1'h1;
        apb(1'h1, RHPM_OFS_CTRL, 32'h0000_0003);
        wt();
        chk(32'({link_request_to_send_n, host_wake_pin_oe, host_wake_pin_out, voice_data_in,
                 audio_bit_clock_oe, core_tx_allowed, core_three_wire, link_serial_out}),
            32'hF6);
        @(posedge pclk);
        voice_clk_out  <= 1'h0;
        voice_sync_out <= 1'h0;
        host_dev_wake  <= 1'h0;
        wt();
        chk(32'({link_request_to_send_n, host_wake_pin_out, voice_data_in}), 32'h0);
        report_and_stop();
    end
endmodule
